// >>> sopm_pkg.sv
// Package for the sense output pin mux: offsets, field layouts, codes, timing.
// Assumes a register access port inside the device supplies word writes and reads.
package sopm_pkg;
  localparam logic [8:0] FLAG_DIR_ADDR = 9'h1C1;
  localparam logic [8:0] FLAG_SRC_ADDR = 9'h1C3;
  localparam logic [8:0] PIN_CFG_ADDR  = 9'h1C4;
  localparam int REG_W        = 16;
  localparam int FLAG_PIN_ONE = 10;
  localparam int FLAG_PIN_TWO = 11;
  // Own config register layout, per pin p at base p*8
  localparam int CFG_SRC_SEL  = 0;
  localparam int CFG_AN_EN    = 1;
  localparam int CFG_GAIN_LO  = 2;
  localparam int CFG_CODE_LO  = 4;
  localparam int CFG_PIN_STEP = 8;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [1:0] GAIN_RST = 2'h0;
  localparam int CLK_MHZ      = 100;
  localparam int GAIN_SETTLE_NS = 2000;
  localparam int MUX_SETTLE_NS  = 10000;
  localparam int GAIN_SETTLE_CYC = (GAIN_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int MUX_SETTLE_CYC  = (MUX_SETTLE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    SOPM_SRC_MEAS_A = 3'b000,
    SOPM_SRC_MEAS_B = 3'b001,
    SOPM_SRC_REF    = 3'b101
  } sopm_code_e;

  typedef enum logic [1:0] {
    SOPM_MODE_OFF   = 2'b00,
    SOPM_MODE_ANA   = 2'b01,
    SOPM_MODE_DIN   = 2'b10,
    SOPM_MODE_DOUT  = 2'b11
  } sopm_mode_e;

  typedef struct packed {
    logic       buf_on;
    logic       drive_ctl;
    logic       digital_sel;
    logic [1:0] analog_sel;
    logic [1:0] gain_code;
    logic       flag_value;
    logic       settled;
  } sopm_pin_s;
endpackage

// >>> sopm_mux.sv
// Sense output pin mux: per-pin buffer, source, gain and flag path control.
// Assumes synchronous register port and flag bus signals on the system clock.
`timescale 1ns/1ns
module sopm_mux #(
  parameter int GAIN_CYC = sopm_pkg::GAIN_SETTLE_CYC,
  parameter int MUX_CYC  = sopm_pkg::MUX_SETTLE_CYC
) (
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [8:0]                   reg_addr,
  input  wire logic [sopm_pkg::REG_W-1:0]   reg_wdata,
  output logic      [sopm_pkg::REG_W-1:0]   reg_rdata,
  output logic                              reg_rvalid,
  input  wire logic [1:0]                   pin_flag_out_value,
  input  wire logic [1:0]                   sense_pin_in,
  output logic      [1:0]                   flag_in_value,
  output sopm_pkg::sopm_pin_s               sense_out_pin_one,
  output sopm_pkg::sopm_pin_s               sense_out_pin_two
);
  logic [15:0]         dir_reg;
  logic [15:0]         src_reg;
  logic [15:0]         cfg_reg;
  logic [15:0]         cnt_reg [2];
  logic                cfg_wr;
  logic [1:0]          flag_src_bits;
  logic [1:0]          flag_dir_bits;
  sopm_pkg::sopm_pin_s pin_next [2];

  // Flag lines 10 and 11 as a two-bit per-pin vector
  function automatic logic [1:0] flag_bits(input logic [15:0] r);
    flag_bits = {r[sopm_pkg::FLAG_PIN_TWO], r[sopm_pkg::FLAG_PIN_ONE]};
  endfunction

  // One pin's byte of the pin config word
  function automatic logic [7:0] pin_cfg(input logic [15:0] r, input int p);
    pin_cfg = r[p*sopm_pkg::CFG_PIN_STEP +: 8];
  endfunction

  // Fields whose change re-routes the amplifier input
  function automatic logic [4:0] route_fields(input logic [7:0] b);
    route_fields = {b[sopm_pkg::CFG_CODE_LO +: 3],
                    b[sopm_pkg::CFG_AN_EN],
                    b[sopm_pkg::CFG_SRC_SEL]};
  endfunction

  // Amplifier gain field alone
  function automatic logic [1:0] gain_field(input logic [7:0] b);
    gain_field = b[sopm_pkg::CFG_GAIN_LO +: 2];
  endfunction

  // Pin role from flag source, flag direction and source select
  function automatic sopm_pkg::sopm_mode_e pin_mode(input logic fsrc,
                                                    input logic fdir,
                                                    input logic psel);
    pin_mode = sopm_pkg::SOPM_MODE_OFF;
    if (fsrc && psel) begin
      if (fdir) begin
        pin_mode = sopm_pkg::SOPM_MODE_DIN;
      end else begin
        pin_mode = sopm_pkg::SOPM_MODE_DOUT;
      end
    end else if (!fsrc && !psel) begin
      pin_mode = sopm_pkg::SOPM_MODE_ANA;
    end
  endfunction

  // Analog source code to measurement, reference or nothing
  function automatic logic [1:0] analog_route(input logic [2:0] code);
    case (code)
      sopm_pkg::SOPM_SRC_MEAS_A: analog_route = 2'h1;
      sopm_pkg::SOPM_SRC_MEAS_B: analog_route = 2'h2;
      sopm_pkg::SOPM_SRC_REF:    analog_route = 2'h3;
      default:                   analog_route = 2'h0;
    endcase
  endfunction

  // Register read multiplexer, unmapped addresses read zero
  function automatic logic [15:0] read_mux(input logic [8:0]  a,
                                           input logic [15:0] d,
                                           input logic [15:0] s,
                                           input logic [15:0] c);
    case (a)
      sopm_pkg::FLAG_DIR_ADDR: read_mux = d;
      sopm_pkg::FLAG_SRC_ADDR: read_mux = s;
      sopm_pkg::PIN_CFG_ADDR:  read_mux = c;
      default:                 read_mux = 16'h0000;
    endcase
  endfunction

  assign cfg_wr        = reg_wr && (reg_addr == sopm_pkg::PIN_CFG_ADDR);
  assign flag_src_bits = flag_bits(src_reg);
  assign flag_dir_bits = flag_bits(dir_reg);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dir_reg <= sopm_pkg::REG_RST;
    end else if (reg_wr && reg_addr == sopm_pkg::FLAG_DIR_ADDR) begin
      dir_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      src_reg <= sopm_pkg::REG_RST;
    end else if (reg_wr && reg_addr == sopm_pkg::FLAG_SRC_ADDR) begin
      src_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_reg <= sopm_pkg::REG_RST;
    end else if (cfg_wr) begin
      cfg_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_rdata  <= read_mux(reg_addr, dir_reg, src_reg, cfg_reg);
    end
  end

  // Per-pin mode decode
  always_comb begin
    logic [7:0]           c;
    logic [2:0]           code;
    sopm_pkg::sopm_mode_e mode;
    c           = 8'h00;
    code        = 3'h0;
    mode        = sopm_pkg::SOPM_MODE_OFF;
    pin_next[0] = '0;
    pin_next[1] = '0;
    for (int p = 0; p < 2; p++) begin
      c    = pin_cfg(cfg_reg, p);
      code = c[sopm_pkg::CFG_CODE_LO +: 3];
      mode = pin_mode(flag_src_bits[p], flag_dir_bits[p], c[sopm_pkg::CFG_SRC_SEL]);
      pin_next[p].gain_code   = gain_field(c);
      pin_next[p].digital_sel = c[sopm_pkg::CFG_SRC_SEL];
      case (mode)
        sopm_pkg::SOPM_MODE_DIN: begin
          pin_next[p].buf_on    = 1'b0;
          pin_next[p].drive_ctl = 1'b0;
        end
        sopm_pkg::SOPM_MODE_DOUT: begin
          pin_next[p].buf_on     = 1'b1;
          pin_next[p].drive_ctl  = 1'b1;
          pin_next[p].flag_value = pin_flag_out_value[p];
        end
        sopm_pkg::SOPM_MODE_ANA: begin
          pin_next[p].buf_on = c[sopm_pkg::CFG_AN_EN];
          if (c[sopm_pkg::CFG_AN_EN]) begin
            pin_next[p].analog_sel = analog_route(code);
          end
        end
        default: begin
          // Source and select disagree: keep the pin quiet
          pin_next[p].buf_on    = 1'b0;
          pin_next[p].drive_ctl = 1'b0;
        end
      endcase
      pin_next[p].settled = (cnt_reg[p] == 16'h0000);
    end
  end

  // Settle counters restart on gain or mux change
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg[0] <= 16'h0000;
      cnt_reg[1] <= 16'h0000;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (cfg_wr && route_fields(pin_cfg(reg_wdata, p)) !=
                      route_fields(pin_cfg(cfg_reg, p))) begin
          cnt_reg[p] <= 16'(MUX_CYC);
        end else if (cfg_wr && gain_field(pin_cfg(reg_wdata, p)) !=
                               gain_field(pin_cfg(cfg_reg, p))) begin
          cnt_reg[p] <= 16'(GAIN_CYC);
        end else if (cnt_reg[p] != 16'h0000) begin
          cnt_reg[p] <= cnt_reg[p] - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sense_out_pin_one <= '0;
      sense_out_pin_two <= '0;
    end else begin
      sense_out_pin_one <= pin_next[0];
      sense_out_pin_two <= pin_next[1];
    end
  end

  // Pin level reaches the flag bus whenever flag source and flag direction bits are set, whatever the source select
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_in_value <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        flag_in_value[p] <= flag_src_bits[p] & flag_dir_bits[p] & sense_pin_in[p];
      end
    end
  end
endmodule

// >>> sopm_mux_sva.sv
// Checker for the sense output pin mux, bound to its ports.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ns
module sopm_mux_sva (
  input wire logic                clock,
  input wire logic                rst,
  input wire logic                reg_rd,
  input wire logic [8:0]          reg_addr,
  input wire logic [15:0]         reg_rdata,
  input wire logic                reg_rvalid,
  input wire logic [1:0]          pin_flag_out_value,
  input wire logic [1:0]          sense_pin_in,
  input wire logic [1:0]          flag_in_value,
  input wire sopm_pkg::sopm_pin_s sense_out_pin_one,
  input wire sopm_pkg::sopm_pin_s sense_out_pin_two
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_rd_answer: assert property (reg_rd |=> reg_rvalid) else $error("read unanswered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray rvalid");
  a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {9'h1C1, 9'h1C3, 9'h1C4})
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_drive_buf: assert property (sense_out_pin_one.drive_ctl |-> sense_out_pin_one.buf_on)
    else $error("drive without buffer");
  a_drive_digital: assert property (sense_out_pin_two.drive_ctl |-> sense_out_pin_two.digital_sel)
    else $error("drive on analog path");
  a_flag_follow: assert property (sense_out_pin_one.drive_ctl && $past(sense_out_pin_one.drive_ctl)
    |-> sense_out_pin_one.flag_value == $past(pin_flag_out_value[0])) else $error("flag value");
  a_flag_in_pin: assert property (flag_in_value[1] |-> $past(sense_pin_in[1]))
    else $error("flag input without pin level");
  a_analog_no_drv: assert property (!sense_out_pin_one.digital_sel |-> !sense_out_pin_one.drive_ctl)
    else $error("analog mode drives flag");
endmodule

// >>> sopm_host.sv
// Host side of the sense pins: resolves the wire level seen by the device.
// Assumes the host drives a level whenever the device buffer is off.
`timescale 1ns/1ns
module sopm_host (
  input  wire logic [1:0] buf_on,
  input  wire logic [1:0] drv,
  input  wire logic [1:0] ext,
  output logic      [1:0] sense_pin_in
);
  assign sense_pin_in = (buf_on & drv) | (~buf_on & ext);
endmodule

// >>> sopm_mux_tb.sv
// Self-checking bench for the sense output pin mux with random configurations.
// Assumes short settle counts through the design parameters.
`timescale 1ns/1ns
`define CHK(a,b) begin n_checks++; if ((a)!==(b)) begin error_cnt++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
bind sopm_mux sopm_mux_sva chk (.clock(clock), .rst(rst), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pin_flag_out_value(pin_flag_out_value),
  .sense_pin_in(sense_pin_in), .flag_in_value(flag_in_value),
  .sense_out_pin_one(sense_out_pin_one), .sense_out_pin_two(sense_out_pin_two));
module sopm_mux_tb;
  logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, reg_rvalid, fs, fd, ps, en;
  logic [8:0] reg_addr = 9'h000;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, src, dir, cfg;
  logic [1:0] pin_flag_out_value = 2'h0, ext = 2'h0, sense_pin_in, flag_in_value;
  logic [2:0] cd;
  sopm_pkg::sopm_pin_s sense_out_pin_one, sense_out_pin_two, p;
  int error_cnt = 0, n_checks = 0, seed = 32'hf834;
  always #5 clock = ~clock;
  sopm_mux #(.GAIN_CYC(4), .MUX_CYC(8)) uut (.clock(clock), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pin_flag_out_value(pin_flag_out_value), .sense_pin_in(sense_pin_in),
    .flag_in_value(flag_in_value), .sense_out_pin_one(sense_out_pin_one),
    .sense_out_pin_two(sense_out_pin_two));
  sopm_host host (.buf_on({sense_out_pin_two.buf_on, sense_out_pin_one.buf_on}), .ext(ext),
    .drv({sense_out_pin_two.flag_value, sense_out_pin_one.flag_value}), .sense_pin_in(sense_pin_in));
  task wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clock); reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge clock); reg_wr <= 0;
  endtask
  task rd(input logic [8:0] a, input logic [15:0] e);
    @(posedge clock); reg_rd <= 1; reg_addr <= a;
    @(posedge clock); reg_rd <= 0;
    #1 `CHK(reg_rdata, e)
    `CHK(reg_rvalid, 1'b1)
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000 error_cnt++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 0;
    rd(9'h1C1, 16'h0000);
    rd(9'h1C3, 16'h0000);
    for (int i = 0; i < 48; i++) begin
      src = $random(seed); dir = $random(seed); cfg = $random(seed);
      @(posedge clock); pin_flag_out_value <= 2'($random(seed)); ext <= 2'($random(seed));
      wr(9'h1C1, dir); wr(9'h1C3, src); wr(9'h1C4, cfg);
      repeat (12) @(posedge clock);
      #1;
      for (int k = 0; k < 2; k++) begin
        p = k ? sense_out_pin_two : sense_out_pin_one;
        fs = src[10+k]; fd = dir[10+k]; ps = cfg[8*k]; en = cfg[8*k+1]; cd = cfg[8*k+4 +: 3];
        `CHK(p.gain_code, cfg[8*k+2 +: 2])
        `CHK(p.settled, 1'h1)
        `CHK(flag_in_value[k], fs & fd & ext[k])
        if (fs == ps) begin
          `CHK(p.digital_sel, ps)
          `CHK(p.buf_on, ps ? !fd : en)
          `CHK(p.drive_ctl, ps & !fd)
          if (ps & !fd) `CHK(p.flag_value, pin_flag_out_value[k])
          if (!ps & en) `CHK(p.analog_sel, cd == 3'h0 ? 2'h1 : cd == 3'h1 ? 2'h2 : cd == 3'h5 ? 2'h3 : 2'h0)
        end else `CHK(p.buf_on, 1'h0)
      end
      rd(9'h1C1, dir);
      rd(9'h1C3, src);
      rd(9'h1C4, cfg);
      rd(9'h1C5, 16'h0000);
    end
    $display("random mux test done");
    @(posedge clock); rst <= 1;
    @(posedge clock); rst <= 0;
    rd(9'h1C3, 16'h0000);
    $display("mid-run reset test done");
    print_verdict;
  end
endmodule
